// ### src/pcfgl_map.svh
`ifndef PCFGL_MAP_SVH
`define PCFGL_MAP_SVH
// Configuration space offsets (byte addresses)
`define PCFGL_OFF_ID 12'h000
`define PCFGL_OFF_CLASS 12'h008
`define PCFGL_OFF_SUBSYS 12'h02C
`define PCFGL_OFF_PM_CAP 12'h078
`define PCFGL_OFF_PM_CSR 12'h07C
`define PCFGL_OFF_EXP_CAP 12'h080
`define PCFGL_OFF_DEV_CAP 12'h084
`define PCFGL_OFF_DEV_CTL 12'h088
`define PCFGL_OFF_LINK_CAP 12'h08C
`define PCFGL_OFF_LINK_CS 12'h090
`define PCFGL_OFF_SLOT_CAP 12'h094
`define PCFGL_OFF_RSVD_A_LO 12'h098
`define PCFGL_OFF_RSVD_A_HI 12'h0AF
`define PCFGL_OFF_LINK_CS2 12'h0B0
`define PCFGL_OFF_VC_CAP 12'h100
`define PCFGL_OFF_VC_PORT 12'h114
// Read-only register contents
`define PCFGL_VAL_PM_CAP 32'h4803_8001
`define PCFGL_VAL_PM_CSR 32'h0000_0008
`define PCFGL_VAL_EXP_CAP 32'h0202_0010
`define PCFGL_VAL_DEV_CAP 32'h0000_8001
`define PCFGL_VAL_LINK_CAP 32'h0100_0C11
`define PCFGL_VAL_LINK_CS 32'h0011_0011
`define PCFGL_VAL_SLOT_CAP 32'h0004_0000
`define PCFGL_VAL_LINK_CS2 32'h0001_0001
`define PCFGL_VAL_VC_CAP 32'h0001_0002
// Reset values
`define PCFGL_RST_DEV_CTL 16'h2810
`define PCFGL_RST_CLASS_LO 16'h0200
`define PCFGL_RST_CLASS_HI 16'h0700
`define PCFGL_RST_SUBSYS 16'h0000
// Address word fields
`define PCFGL_AW_PARITY 15
`define PCFGL_AW_FINAL 14
`define PCFGL_TGT_VENDOR 8'h00
`define PCFGL_TGT_DEVICE 8'h01
`define PCFGL_TGT_CLASS_LO 8'h02
`define PCFGL_TGT_CLASS_HI 8'h03
`define PCFGL_TGT_SUB_VENDOR 8'h04
`define PCFGL_TGT_SUB_ID 8'h05
// Status bit for a pair parity error
`define PCFGL_ST_PARITY 3
// Serial read frame
`define PCFGL_EEP_ADDR_BITS 6
`define PCFGL_EEP_READ_CMD 3'b110
`define PCFGL_FIRST_DATA_SLOT 5'd9
`define PCFGL_LAST_SLOT 5'd24
// Timing
`define PCFGL_SK_HALF_NS 300
`define PCFGL_LINK_PERIOD_NS 6
`endif

// ### src/pcfgl_pkg.sv
package pcfgl_pkg;
	typedef enum logic [3:0] {
		S_REQ = 4'b0001,
		S_WAIT = 4'b0010,
		S_APPLY = 4'b0100,
		S_DONE = 4'b1000
	} pcfgl_sys_state_t;
	typedef enum logic [3:0] {
		L_IDLE = 4'b0001,
		L_SEL = 4'b0010,
		L_SHIFT = 4'b0100,
		L_END = 4'b1000
	} pcfgl_link_state_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcfgl_cfg_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} pcfgl_cfg_rsp_t;
	typedef struct packed {
		logic cs;
		logic sk;
		logic di;
	} pcfgl_eep_pins_t;
	typedef struct packed {
		logic [15:0] vendor;
		logic [15:0] device;
		logic [23:0] class_code;
		logic [15:0] sub_vendor;
		logic [15:0] sub_id;
	} pcfgl_ident_t;
endpackage

// ### src/pcfgl_loader.sv
`timescale 1ns/100ps
`include "pcfgl_map.svh"
// Functional notes
// - Power-up reads 16-bit EEPROM words into configuration
// - Words consumed as address then data pairs
// - Odd parity over each 32-bit pair
// - Parity error sets status bit 3
// - Address bit 14 set ends loading
// - Target selector picks one of six fields
// - Class low target uses upper byte
// - Pairs applied in any order
// - Unnamed targets keep built-in defaults
// - Power management capability header constant
// - Power control word reports no soft reset
// - Express capability header ends the list
// - Device capabilities constant, upper half zero
// - Device control writable, resets to 0x2810
// - Link capabilities constant
// - Link control status constant
// - Slot capabilities read 0x00040000
// - Link status two reads 0x00010001
// - Virtual channel capability reads 0x00010002
// - Unimplemented ranges read zero
// - Subsystem fields loaded, reset to zero
module pcfgl_loader #(
	parameter logic [15:0] VENDOR_DEF = 16'h1A2B, // Arbitrary value
	parameter logic [15:0] DEVICE_DEF = 16'h3C4D, // Arbitrary value
	parameter logic [7:0] REVISION = 8'h01, // Arbitrary value
	parameter logic [31:0] VC_PORT_CAPS = 32'h8000_00FF,
	parameter int SK_HALF_CYC = (`PCFGL_SK_HALF_NS
		+ `PCFGL_LINK_PERIOD_NS - 1) / `PCFGL_LINK_PERIOD_NS
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic clk_link_i,
	input wire pcfgl_pkg::pcfgl_cfg_req_t cfg_req_i,
	output pcfgl_pkg::pcfgl_cfg_rsp_t cfg_rsp_o,
	input wire logic eep_do_i,
	output pcfgl_pkg::pcfgl_eep_pins_t eep_pins_o,
	output logic [7:0] misc_device_status_o,
	output logic load_done_o
);
	localparam int AW = `PCFGL_EEP_ADDR_BITS;
	localparam logic [7:0] HALF_LAST = 8'(SK_HALF_CYC - 1);
	// Named copies so their bits can be selected; literals cannot be
	localparam logic [2:0] READ_CMD = `PCFGL_EEP_READ_CMD;
	localparam logic [15:0] CLASS_LO_RST = `PCFGL_RST_CLASS_LO;

	////////////////////////////////////////////////////////////////////////
	// System domain state
	pcfgl_pkg::pcfgl_sys_state_t state_ff, nxt_state;
	logic [AW-1:0] word_addr_ff, nxt_word_addr;
	logic second_ff, nxt_second;
	logic [15:0] addr_word_ff, nxt_addr_word;
	logic [15:0] data_word_ff, nxt_data_word;
	logic req_tgl_ff, nxt_req_tgl;
	logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
	pcfgl_pkg::pcfgl_ident_t ident_ff, nxt_ident;
	logic [7:0] status_ff, nxt_status;
	logic done_ff, nxt_done;
	logic [15:0] devctl_ff, nxt_devctl;
	pcfgl_pkg::pcfgl_cfg_rsp_t rsp_ff, nxt_rsp;
	logic ack_evt, par_ok, is_final, ident_hit, take;
	logic [7:0] target;
	logic [31:0] rd_val;

	////////////////////////////////////////////////////////////////////////
	// Link domain state
	logic lrst_s1_ff, lrst_s2_ff;
	logic req_s1_ff, req_s2_ff, req_s3_ff;
	logic do_s1_ff, do_s2_ff;
	pcfgl_pkg::pcfgl_link_state_t lstate_ff, nxt_lstate;
	logic [7:0] half_ff, nxt_half;
	logic [4:0] slot_ff, nxt_slot;
	logic phase_ff, nxt_phase;
	logic [8:0] cmd_ff, nxt_cmd;
	logic [15:0] sh_ff, nxt_sh;
	logic [15:0] word_ff, nxt_word;
	logic ack_tgl_ff, nxt_ack_tgl;
	pcfgl_pkg::pcfgl_eep_pins_t pins_ff, nxt_pins;
	logic half_end;

	assign ack_evt = ack_s2_ff ^ ack_s3_ff;
	assign par_ok = ^{addr_word_ff, data_word_ff};
	assign is_final = addr_word_ff[`PCFGL_AW_FINAL];
	assign target = addr_word_ff[7:0];

	// Loader sequencer: fetch address word, then data word, then apply
	always_comb begin
		nxt_state = state_ff;
		nxt_word_addr = word_addr_ff;
		nxt_second = second_ff;
		nxt_addr_word = addr_word_ff;
		nxt_data_word = data_word_ff;
		nxt_req_tgl = req_tgl_ff;
		nxt_ident = ident_ff;
		nxt_status = status_ff;
		nxt_done = done_ff;
		unique case (state_ff)
			pcfgl_pkg::S_REQ: begin
				nxt_req_tgl = ~req_tgl_ff;
				nxt_state = pcfgl_pkg::S_WAIT;
			end
			pcfgl_pkg::S_WAIT: begin
				if (ack_evt) begin
					nxt_word_addr = word_addr_ff + 1'b1;
					nxt_second = ~second_ff;
					// First word of a pair is the address word
					if (!second_ff) begin
						nxt_addr_word = word_ff;
						nxt_state = pcfgl_pkg::S_REQ;
					end else begin
						nxt_data_word = word_ff;
						nxt_state = pcfgl_pkg::S_APPLY;
					end
				end
			end
			pcfgl_pkg::S_APPLY: begin
				if (!par_ok) begin
					// Flag and stop; pair is dropped
					nxt_status[`PCFGL_ST_PARITY] = 1'b1;
					nxt_done = 1'b1;
					nxt_state = pcfgl_pkg::S_DONE;
				end else begin
					// Position in the image does not matter
					// Unknown selectors change nothing
					case (target)
						`PCFGL_TGT_VENDOR: nxt_ident.vendor = data_word_ff;
						`PCFGL_TGT_DEVICE: nxt_ident.device = data_word_ff;
						`PCFGL_TGT_CLASS_LO: begin
							nxt_ident.class_code[7:0] = data_word_ff[15:8];
						end
						`PCFGL_TGT_CLASS_HI: begin
							nxt_ident.class_code[23:8] = data_word_ff;
						end
						`PCFGL_TGT_SUB_VENDOR: begin
							nxt_ident.sub_vendor = data_word_ff;
						end
						`PCFGL_TGT_SUB_ID: nxt_ident.sub_id = data_word_ff;
						default: nxt_ident = ident_ff;
					endcase
					// Wrapped address means the image ran out
					if (is_final || word_addr_ff == '0) begin
						nxt_done = 1'b1;
						nxt_state = pcfgl_pkg::S_DONE;
					end else begin
						nxt_state = pcfgl_pkg::S_REQ;
					end
				end
			end
			pcfgl_pkg::S_DONE: nxt_state = pcfgl_pkg::S_DONE;
		endcase
	end

	// Loader registers; defaults hold until a pair overrides them
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_ff <= pcfgl_pkg::S_REQ;
			word_addr_ff <= '0;
			second_ff <= 1'b0;
			addr_word_ff <= 16'h0000;
			data_word_ff <= 16'h0000;
			req_tgl_ff <= 1'b0;
			ident_ff.vendor <= VENDOR_DEF;
			ident_ff.device <= DEVICE_DEF;
			ident_ff.class_code <= {`PCFGL_RST_CLASS_HI,
				CLASS_LO_RST[15:8]};
			ident_ff.sub_vendor <= `PCFGL_RST_SUBSYS;
			ident_ff.sub_id <= `PCFGL_RST_SUBSYS;
			status_ff <= 8'h00;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			word_addr_ff <= nxt_word_addr;
			second_ff <= nxt_second;
			addr_word_ff <= nxt_addr_word;
			data_word_ff <= nxt_data_word;
			req_tgl_ff <= nxt_req_tgl;
			ident_ff <= nxt_ident;
			status_ff <= nxt_status;
			done_ff <= nxt_done;
		end
	end

	// Ack toggle from the link side; stages two and three feed logic
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
			ack_s3_ff <= 1'b0;
		end else begin
			ack_s1_ff <= ack_tgl_ff;
			ack_s2_ff <= ack_s1_ff;
			ack_s3_ff <= ack_s2_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration access
	assign ident_hit = cfg_req_i.addr == `PCFGL_OFF_ID
		|| cfg_req_i.addr == `PCFGL_OFF_CLASS
		|| cfg_req_i.addr == `PCFGL_OFF_SUBSYS;
	// Identity reads stall so software never sees half-loaded IDs
	assign take = cfg_req_i.req && !rsp_ff.ack
		&& (done_ff || cfg_req_i.we || !ident_hit);

	// Read decode; anything not listed returns zero
	always_comb begin
		unique case (cfg_req_i.addr)
			`PCFGL_OFF_ID: rd_val = {ident_ff.device, ident_ff.vendor};
			`PCFGL_OFF_CLASS: rd_val = {ident_ff.class_code, REVISION};
			`PCFGL_OFF_SUBSYS: begin
				rd_val = {ident_ff.sub_id, ident_ff.sub_vendor};
			end
			`PCFGL_OFF_PM_CAP: rd_val = `PCFGL_VAL_PM_CAP;
			`PCFGL_OFF_PM_CSR: rd_val = `PCFGL_VAL_PM_CSR;
			`PCFGL_OFF_EXP_CAP: rd_val = `PCFGL_VAL_EXP_CAP;
			`PCFGL_OFF_DEV_CAP: rd_val = `PCFGL_VAL_DEV_CAP;
			`PCFGL_OFF_DEV_CTL: rd_val = {16'h0000, devctl_ff};
			`PCFGL_OFF_LINK_CAP: rd_val = `PCFGL_VAL_LINK_CAP;
			`PCFGL_OFF_LINK_CS: rd_val = `PCFGL_VAL_LINK_CS;
			`PCFGL_OFF_SLOT_CAP: rd_val = `PCFGL_VAL_SLOT_CAP;
			`PCFGL_OFF_LINK_CS2: rd_val = `PCFGL_VAL_LINK_CS2;
			`PCFGL_OFF_VC_CAP: rd_val = `PCFGL_VAL_VC_CAP;
			`PCFGL_OFF_VC_PORT: rd_val = VC_PORT_CAPS;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// One-cycle ack; writes land only in the device control bytes
	always_comb begin
		nxt_rsp.ack = take;
		nxt_rsp.rdata = rsp_ff.rdata;
		nxt_devctl = devctl_ff;
		if (take && !cfg_req_i.we) begin
			nxt_rsp.rdata = rd_val;
		end
		if (take && cfg_req_i.we
			&& cfg_req_i.addr == `PCFGL_OFF_DEV_CTL) begin
			if (cfg_req_i.be[0]) begin
				nxt_devctl[7:0] = cfg_req_i.wdata[7:0];
			end
			if (cfg_req_i.be[1]) begin
				nxt_devctl[15:8] = cfg_req_i.wdata[15:8];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rsp_ff <= '0;
			devctl_ff <= `PCFGL_RST_DEV_CTL;
		end else begin
			rsp_ff <= nxt_rsp;
			devctl_ff <= nxt_devctl;
		end
	end

	assign cfg_rsp_o = rsp_ff;
	assign misc_device_status_o = status_ff;
	assign load_done_o = done_ff;

	////////////////////////////////////////////////////////////////////////
	// Link domain: reset, request toggle and data pin synchronisers
	always_ff @(posedge clk_link_i) begin
		lrst_s1_ff <= rst_i;
		lrst_s2_ff <= lrst_s1_ff;
		do_s1_ff <= eep_do_i;
		do_s2_ff <= do_s1_ff;
	end

	always_ff @(posedge clk_link_i) begin
		if (lrst_s2_ff) begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_s3_ff <= 1'b0;
		end else begin
			req_s1_ff <= req_tgl_ff;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
		end
	end

	assign half_end = half_ff == HALF_LAST;

	// Serial read frame: start, opcode, six address bits, 16 data bits
	always_comb begin
		nxt_lstate = lstate_ff;
		nxt_half = half_ff;
		nxt_slot = slot_ff;
		nxt_phase = phase_ff;
		nxt_cmd = cmd_ff;
		nxt_sh = sh_ff;
		nxt_word = word_ff;
		nxt_ack_tgl = ack_tgl_ff;
		nxt_pins = pins_ff;
		unique case (lstate_ff)
			pcfgl_pkg::L_IDLE: begin
				nxt_pins = '0;
				// Word address is stable while the request is open
				if (req_s2_ff ^ req_s3_ff) begin
					// Start bit and opcode, then the word address
					nxt_cmd = {READ_CMD, word_addr_ff};
					nxt_half = 8'h00;
					nxt_pins.cs = 1'b1;
					nxt_lstate = pcfgl_pkg::L_SEL;
				end
			end
			pcfgl_pkg::L_SEL: begin
				nxt_half = half_ff + 8'h01;
				if (half_end) begin
					nxt_half = 8'h00;
					nxt_slot = 5'd0;
					nxt_phase = 1'b0;
					nxt_pins.di = cmd_ff[8];
					nxt_cmd = {cmd_ff[7:0], 1'b0};
					nxt_lstate = pcfgl_pkg::L_SHIFT;
				end
			end
			pcfgl_pkg::L_SHIFT: begin
				nxt_half = half_ff + 8'h01;
				if (half_end) begin
					nxt_half = 8'h00;
					nxt_phase = ~phase_ff;
					nxt_pins.sk = ~phase_ff;
					// Sample late in the high phase, past sync delay
					if (phase_ff) begin
						if (slot_ff >= `PCFGL_FIRST_DATA_SLOT) begin
							nxt_sh = {sh_ff[14:0], do_s2_ff};
						end
						nxt_pins.di = cmd_ff[8];
						nxt_cmd = {cmd_ff[7:0], 1'b0};
						nxt_slot = slot_ff + 5'd1;
						if (slot_ff == `PCFGL_LAST_SLOT) begin
							nxt_lstate = pcfgl_pkg::L_END;
						end
					end
				end
			end
			pcfgl_pkg::L_END: begin
				nxt_pins = '0;
				nxt_word = sh_ff;
				nxt_ack_tgl = ~ack_tgl_ff;
				nxt_lstate = pcfgl_pkg::L_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_link_i) begin
		if (lrst_s2_ff) begin
			lstate_ff <= pcfgl_pkg::L_IDLE;
			half_ff <= 8'h00;
			slot_ff <= 5'd0;
			phase_ff <= 1'b0;
			cmd_ff <= 9'h000;
			sh_ff <= 16'h0000;
			word_ff <= 16'h0000;
			ack_tgl_ff <= 1'b0;
			pins_ff <= '0;
		end else begin
			lstate_ff <= nxt_lstate;
			half_ff <= nxt_half;
			slot_ff <= nxt_slot;
			phase_ff <= nxt_phase;
			cmd_ff <= nxt_cmd;
			sh_ff <= nxt_sh;
			word_ff <= nxt_word;
			ack_tgl_ff <= nxt_ack_tgl;
			pins_ff <= nxt_pins;
		end
	end

	assign eep_pins_o = pins_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_parity_flag;
		@(posedge clk_sys_i) disable iff (rst_i)
		state_ff == pcfgl_pkg::S_APPLY && !par_ok
		|=> status_ff[`PCFGL_ST_PARITY] && done_ff;
	endproperty
	a_parity_flag: assert property (p_parity_flag)
		else $error("parity error not flagged");

	property p_bad_pair_dropped;
		@(posedge clk_sys_i) disable iff (rst_i)
		state_ff == pcfgl_pkg::S_APPLY && !par_ok
		|=> ident_ff == $past(ident_ff);
	endproperty
	a_bad_pair_dropped: assert property (p_bad_pair_dropped)
		else $error("bad parity pair was applied");

	property p_final_stops;
		@(posedge clk_sys_i) disable iff (rst_i)
		state_ff == pcfgl_pkg::S_APPLY && par_ok && is_final
		|=> state_ff == pcfgl_pkg::S_DONE [*3];
	endproperty
	a_final_stops: assert property (p_final_stops)
		else $error("loader did not stop on final pair");

	property p_continue;
		@(posedge clk_sys_i) disable iff (rst_i)
		state_ff == pcfgl_pkg::S_APPLY && par_ok && !is_final
		&& word_addr_ff != '0
		|=> state_ff == pcfgl_pkg::S_REQ ##1 $changed(req_tgl_ff);
	endproperty
	a_continue: assert property (p_continue)
		else $error("loader did not fetch next pair");

	property p_apply_vendor;
		@(posedge clk_sys_i) disable iff (rst_i)
		state_ff == pcfgl_pkg::S_APPLY && par_ok
		&& target == `PCFGL_TGT_VENDOR
		|=> ident_ff.vendor == $past(data_word_ff);
	endproperty
	a_apply_vendor: assert property (p_apply_vendor)
		else $error("vendor target not applied");

	property p_class_low;
		@(posedge clk_sys_i) disable iff (rst_i)
		state_ff == pcfgl_pkg::S_APPLY && par_ok
		&& target == `PCFGL_TGT_CLASS_LO
		|=> ident_ff.class_code[7:0] == $past(data_word_ff[15:8])
		&& $stable(ident_ff.class_code[23:8]);
	endproperty
	a_class_low: assert property (p_class_low)
		else $error("class low target misapplied");

	property p_ident_wait;
		@(posedge clk_sys_i) disable iff (rst_i)
		cfg_req_i.req && !cfg_req_i.we && ident_hit && !done_ff
		|=> !rsp_ff.ack;
	endproperty
	a_ident_wait: assert property (p_ident_wait)
		else $error("identity read answered before load end");

	property p_slot_const;
		@(posedge clk_sys_i) disable iff (rst_i)
		take && !cfg_req_i.we && cfg_req_i.addr == `PCFGL_OFF_SLOT_CAP
		|=> rsp_ff.ack && rsp_ff.rdata == 32'h0004_0000;
	endproperty
	a_slot_const: assert property (p_slot_const)
		else $error("slot capabilities value wrong");

	property p_reserved_zero;
		@(posedge clk_sys_i) disable iff (rst_i)
		take && !cfg_req_i.we
		&& cfg_req_i.addr >= `PCFGL_OFF_RSVD_A_LO
		&& cfg_req_i.addr <= `PCFGL_OFF_RSVD_A_HI
		|=> rsp_ff.rdata == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("unimplemented range not zero");

	property p_devctl_reset;
		@(posedge clk_sys_i)
		rst_i |=> devctl_ff == 16'h2810;
	endproperty
	a_devctl_reset: assert property (p_devctl_reset)
		else $error("device control reset value wrong");

	property p_frame_end;
		@(posedge clk_link_i) disable iff (lrst_s2_ff)
		lstate_ff == pcfgl_pkg::L_SHIFT && half_end && phase_ff
		&& slot_ff == `PCFGL_LAST_SLOT
		|=> lstate_ff == pcfgl_pkg::L_END ##1 !pins_ff.cs;
	endproperty
	a_frame_end: assert property (p_frame_end)
		else $error("serial frame did not end after last bit");

	c_load_final: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		state_ff == pcfgl_pkg::S_APPLY && par_ok && is_final);
	c_load_parity: cover property (@(posedge clk_sys_i)
		disable iff (rst_i) state_ff == pcfgl_pkg::S_APPLY && !par_ok);
	c_ident_read: cover property (@(posedge clk_sys_i)
		disable iff (rst_i) take && ident_hit && !cfg_req_i.we);
	c_devctl_write: cover property (@(posedge clk_sys_i)
		disable iff (rst_i) take && cfg_req_i.we
		&& cfg_req_i.addr == `PCFGL_OFF_DEV_CTL);
endmodule

// ### tb/pcfgl_eeprom_model.sv
`timescale 1ns/100ps
// Word-wide serial memory that answers the loader's read frames
module pcfgl_eeprom_model (
	input wire logic cs_i,
	input wire logic sk_i,
	input wire logic di_i,
	output logic do_o,
	output logic cmd_err_o
);
	logic [15:0] mem [0:63];
	logic [15:0] word_q;
	logic [5:0] adr_q;
	logic [2:0] cmd_q;
	int cnt;
	initial begin
		do_o = 1'b0;
		cmd_err_o = 1'b0;
		cnt = 0;
	end
	////////////////////////////////////////////////////////////////////////
	// Bits taken on sk rise; a released line flips so stale data never
	// passes for a fresh bit
	always @(posedge sk_i or negedge cs_i) begin
		if (!cs_i) begin
			cnt <= 0;
			do_o <= ~do_o;
		end else begin
			cnt <= cnt + 1;
			if (cnt < 3)
				cmd_q <= {cmd_q[1:0], di_i};
			if (cnt == 3 && cmd_q != 3'b110)
				cmd_err_o <= 1'b1;
			if (cnt >= 3 && cnt <= 8)
				adr_q <= {adr_q[4:0], di_i};
			if (cnt == 8) begin
				do_o <= 1'b0;
				word_q <= mem[{adr_q[4:0], di_i}];
			end
			if (cnt >= 9 && cnt <= 24)
				do_o <= word_q[24 - cnt];
		end
	end
endmodule

// ### tb/pcfgl_loader_tb.sv
`timescale 1ns/100ps
module pcfgl_loader_tb;
	localparam logic [15:0] VEN = 16'h5A01; // Arbitrary value
	localparam logic [15:0] DEV = 16'h6B02; // Arbitrary value
	localparam logic [7:0] REV = 8'h01; // Arbitrary value
	logic clk_sys_i, clk_link_i, rst_i, eep_do, cmd_err, load_done;
	pcfgl_pkg::pcfgl_cfg_req_t cfg_req;
	pcfgl_pkg::pcfgl_cfg_rsp_t cfg_rsp;
	pcfgl_pkg::pcfgl_eep_pins_t pins;
	logic [7:0] status;
	logic [31:0] rd;
	logic done_at_ack;
	int error_cnt, checks_done, cycles, frames;
	logic [11:0] za [6] = '{12'h098, 12'h0AC, 12'h0B4, 12'h0FC, 12'h104,
		12'h110};

	// Short serial half period keeps each word to under twenty system cycles
	pcfgl_loader #(
		.VENDOR_DEF(VEN),
		.DEVICE_DEF(DEV),
		.REVISION(REV),
		.SK_HALF_CYC(4)
	) dut (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.clk_link_i(clk_link_i),
		.cfg_req_i(cfg_req),
		.cfg_rsp_o(cfg_rsp),
		.eep_do_i(eep_do),
		.eep_pins_o(pins),
		.misc_device_status_o(status),
		.load_done_o(load_done)
	);
	pcfgl_eeprom_model eep (
		.cs_i(pins.cs),
		.sk_i(pins.sk),
		.di_i(pins.di),
		.do_o(eep_do),
		.cmd_err_o(cmd_err)
	);
	////////////////////////////////////////////////////////////////////////
	// Clocks: link clock offset so the two never share edges
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		clk_link_i = 1'b0;
		#1.7;
		forever #3 clk_link_i = ~clk_link_i;
	end
	// Frames seen on the wire, one per word read
	always @(posedge pins.cs)
		frames++;
	// Hang guard, far above the roughly 1600 cycles the run needs
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	// One access; request held until the ack edge, then dropped there
	task automatic cfg(input logic we, input logic [11:0] a,
		input logic [3:0] be, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		cfg_req <= '{req: 1'b1, we: we, addr: a, be: be, wdata: wd};
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (cfg_rsp.ack !== 1'b1 && n < 400);
		rd = cfg_rsp.rdata;
		done_at_ack = load_done;
		cfg_req.req <= 1'b0;
		if (n >= 400)
			chk("ack", 32'h0000_0001, 32'h0000_0000);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		cfg(1'b0, a, 4'h0, 32'h0000_0000);
		chk($sformatf("cfg 0x%h", a), exp, rd);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Image building; unused words are all ones
	task automatic wipe();
		for (int i = 0; i < 64; i++)
			eep.mem[i] = 16'hFFFF;
	endtask
	task automatic put(input int i, input logic [7:0] tgt,
		input logic fin, input logic [15:0] d, input logic bad);
		logic [14:0] aw;
		aw = {fin, 6'h00, tgt};
		eep.mem[2 * i] = {(~^{aw, d}) ^ bad, aw};
		eep.mem[2 * i + 1] = d;
	endtask
	task automatic boot();
		rst_i <= 1'b1;
		repeat (20) @(posedge clk_sys_i);
		frames = 0;
		rst_i <= 1'b0;
	endtask
	task automatic wait_done();
		int n;
		for (n = 0; n < 2000 && load_done !== 1'b1; n++)
			@(posedge clk_sys_i);
		chk("load_done", 32'h1, {31'h0, load_done});
	endtask
	////////////////////////////////////////////////////////////////////////
	// Early identity read stalls; final pair stops the walk
	task automatic t_final();
		wipe();
		put(0, 8'h05, 1'b1, 16'hBEEF, 1'b0);
		put(1, 8'h00, 1'b0, 16'h9999, 1'b0);
		boot();
		rdchk(12'h000, {DEV, VEN});
		chk("done at ack", 32'h1, {31'h0, done_at_ack});
		rdchk(12'h008, {16'h0700, 8'h02, REV});
		rdchk(12'h02C, 32'hBEEF_0000);
		chk("frames", 32'd2, frames);
		chk("cmd err", 32'h0, {31'h0, cmd_err});
		$display("t_final done");
	endtask
	task automatic t_consts();
		rdchk(12'h078, 32'h4803_8001);
		rdchk(12'h07C, 32'h0000_0008);
		rdchk(12'h080, 32'h0202_0010);
		rdchk(12'h084, 32'h0000_8001);
		rdchk(12'h08C, 32'h0100_0C11);
		rdchk(12'h090, 32'h0011_0011);
		cfg(1'b1, 12'h094, 4'hF, 32'hFFFF_FFFF);
		rdchk(12'h094, 32'h0004_0000);
		rdchk(12'h0B0, 32'h0001_0001);
		rdchk(12'h100, 32'h0001_0002);
		foreach (za[i])
			rdchk(za[i], 32'h0000_0000);
		$display("t_consts done");
	endtask
	task automatic t_devctl();
		rdchk(12'h088, 32'h0000_2810);
		cfg(1'b1, 12'h088, 4'hF, 32'hFFFF_ABCD);
		rdchk(12'h088, 32'h0000_ABCD);
		cfg(1'b1, 12'h088, 4'h1, 32'h0000_0055);
		rdchk(12'h088, 32'h0000_AB55);
		$display("t_devctl done");
	endtask
	// A corrupted pair in mid-image
	task automatic t_parity();
		wipe();
		put(0, 8'h04, 1'b0, 16'h1234, 1'b0);
		put(1, 8'h00, 1'b0, 16'h7777, 1'b1);
		put(2, 8'h01, 1'b1, 16'h2222, 1'b0);
		boot();
		wait_done();
		chk("status", 32'h08, {24'h0, status});
		rdchk(12'h000, {DEV, VEN});
		rdchk(12'h02C, 32'h0000_1234);
		rdchk(12'h088, 32'h0000_2810);
		chk("frames", 32'd4, frames);
		$display("t_parity done");
	endtask
	// Every target, listed backwards
	task automatic t_order();
		wipe();
		put(0, 8'h05, 1'b0, 16'h5555, 1'b0);
		put(1, 8'h04, 1'b0, 16'h4444, 1'b0);
		put(2, 8'h03, 1'b0, 16'h0C03, 1'b0);
		put(3, 8'h02, 1'b0, 16'hA53C, 1'b0);
		put(4, 8'h01, 1'b0, 16'h2222, 1'b0);
		put(5, 8'h00, 1'b1, 16'h1111, 1'b0);
		boot();
		wait_done();
		rdchk(12'h000, 32'h2222_1111);
		rdchk(12'h008, {16'h0C03, 8'hA5, REV});
		rdchk(12'h02C, 32'h5555_4444);
		chk("status", 32'h0, {24'h0, status});
		chk("frames", 32'd12, frames);
		$display("t_order done");
	endtask
	// Thirty-two plain pairs; loading ends when the word address wraps
	task automatic t_wrap();
		wipe();
		for (int i = 0; i < 32; i++)
			put(i, 8'h04, 1'b0, {8'hC0, 8'(i)}, 1'b0);
		boot();
		wait_done();
		chk("status", 32'h0, {24'h0, status});
		rdchk(12'h02C, 32'h0000_C01F);
		chk("frames", 32'd64, frames);
		$display("t_wrap done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_i = 1'b1;
		cfg_req = '0;
		error_cnt = 0;
		checks_done = 0;
		cycles = 0;
		frames = 0;
		t_final();
		t_consts();
		t_devctl();
		t_parity();
		t_order();
		t_wrap();
		final_report();
	end
endmodule
